// ==== logic/tst_pkg.sv ====
`default_nettype none
package tst_pkg;
    // ==================================================
    // register offsets and reset value
    localparam logic [7:0] PULLUP_TIMING_OFS = 8'h07;
    localparam logic [7:0] AUTO_TIMING_OFS = 8'h08;
    localparam logic [7:0] APERTURE_OFS = 8'h09;
    localparam logic [7:0] AUX_CFG_OFS = 8'h0a;
    localparam logic [7:0] CFG_RESET = 8'h00;
    // ==================================================
    // field positions
    localparam int HI_NIB_LSB = 4;
    localparam int COARSE_LONG_BIT = 7;
    localparam int AUX_DELAY_LSB = 5;
    localparam int AUX_SAMPLE_LSB = 3;
    localparam int AUX_AVG_LSB = 1;
    localparam int AUX_RES_BIT = 0;
    // ==================================================
    // timing: oscillator ticks derived from microseconds
    localparam int REF_HZ = 100_000_000;
    localparam int OSC_HZ = 2_000_000;
    localparam int OSC_DIV = REF_HZ / OSC_HZ;
    localparam int TICKS_PER_US = OSC_HZ / 1_000_000;
    localparam int TW = 20;
    localparam int COARSE_MIN_US = 2;
    localparam int AUX_SAMPLE_BASE = 4;
    localparam int unsigned TIME16_US [16] = '{10, 20, 50, 80, 100, 200, 500, 800,
        1000, 2000, 5000, 10000, 20000, 50000, 100000, 200000};
    localparam int unsigned FINE_US [16] = '{10, 20, 50, 80, 100, 200, 500, 800,
        1000, 2000, 5000, 10000, 20000, 50000, 50000, 50000};
    localparam int unsigned COARSE_US [4] = '{1000, 2000, 5000, 10000};
    localparam int unsigned AUX_DELAY_US [8] = '{10, 100, 500, 1000, 5000, 10000,
        50000, 100000};

    // microseconds to oscillator ticks
    function automatic logic [TW-1:0] tst_ticks(input int unsigned us);
        tst_ticks = TW'(us * TICKS_PER_US);
    endfunction : tst_ticks

    localparam logic [TW-1:0] COARSE_MIN_TICKS = TW'(COARSE_MIN_US * TICKS_PER_US);

    typedef enum logic [2:0] {
        PU_IDLE = 3'b001,
        PU_COARSE = 3'b010,
        PU_FINE = 3'b100
    } tst_pu_e;
    typedef enum logic [1:0] {
        SC_IDLE = 2'b01,
        SC_RUN = 2'b10
    } tst_sc_e;
    typedef enum logic [2:0] {
        AX_IDLE = 3'b001,
        AX_DELAY = 3'b010,
        AX_SAMPLE = 3'b100
    } tst_ax_e;
endpackage : tst_pkg
`default_nettype wire

// ==== logic/tst_timing_cfg.sv ====
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - fine pullup codes select 10us to 50ms
// - coarse codes 1000-1011 give 1,2,5,10ms
// - coarse minimum: switch off, adds 2us
// - pullup intervals follow every measurement end
// - direct continuous commands skip pullup intervals
// - initial delay from touch to first scan
// - scan period between successive scan blocks
// - scan timing only in autonomous mode
// - x window is 2^(n-1) LSB, 0 off
// - y window uses the same encoding
// - aperture gates fifo logging in autonomous only
// - aux delay codes 10us to 100ms
// - aux sampling 4,16,64,256 oscillator periods
// - aux averaging depth 1,4,8,16 samples
// - aux resolution bit: 0 12-bit, 1 8-bit
// - aperture applies only when filter enabled
module tst_timing_cfg
    import tst_pkg::*;
#(
    parameter int DIV = OSC_DIV
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    output logic [7:0] reg_rdata,
    // sequencer status
    input wire logic direct_mode,
    input wire logic continuous_conversion_bit,
    input wire logic meas_end,
    input wire logic touch_start,
    input wire logic touch_present,
    input wire logic spatial_filter_enable,
    input wire logic median_or_straight_select,
    // position results
    input wire logic pos_valid,
    input wire logic [11:0] pos_x,
    input wire logic [11:0] pos_y,
    // auxiliary request
    input wire logic aux_req,
    // timing outputs
    output logic panel_pullup_switch,
    output logic pullup_busy,
    output logic pullup_done,
    output logic scan_start,
    output logic pos_log,
    output logic aux_sampling,
    output logic aux_convert,
    output logic [1:0] aux_averaging_depth,
    output logic aux_median_filter,
    output logic aux_resolution_select
);
    // ==================================================
    // state
    typedef struct packed {
        logic [7:0] pullup_timing_cfg;
        logic [7:0] autonomous_timing_cfg;
        logic [7:0] aperture_cfg;
        logic [7:0] auxiliary_measure_cfg;
        logic [7:0] rdata;
        logic [7:0] div;
        tst_pu_e pu;
        logic [TW-1:0] pu_cnt;
        logic pu_done;
        tst_sc_e sc;
        logic [TW-1:0] sc_cnt;
        logic scan_start;
        tst_ax_e ax;
        logic [TW-1:0] ax_cnt;
        logic aux_convert;
        logic [11:0] last_x;
        logic [11:0] last_y;
        logic have_last;
        logic pos_log;
    } tst_state_s;

    tst_state_s st_reg;
    tst_state_s st_next;
    logic tick;
    logic [3:0] coarse_code;
    logic [3:0] fine_code;
    logic [3:0] x_code;
    logic [3:0] y_code;
    logic [11:0] dx;
    logic [11:0] dy;
    logic [15:0] x_win;
    logic [15:0] y_win;
    logic moved;
    logic keep_pos;

    // ==================================================
    // oscillator tick and field decode
    assign tick = (st_reg.div == 8'(DIV - 1));
    assign coarse_code = st_reg.pullup_timing_cfg[7:HI_NIB_LSB];
    assign fine_code = st_reg.pullup_timing_cfg[HI_NIB_LSB-1:0];
    assign x_code = st_reg.aperture_cfg[7:HI_NIB_LSB];
    assign y_code = st_reg.aperture_cfg[HI_NIB_LSB-1:0];

    // ==================================================
    // aperture window check
    always_comb begin
        dx = (pos_x >= st_reg.last_x) ? pos_x - st_reg.last_x : st_reg.last_x - pos_x;
        dy = (pos_y >= st_reg.last_y) ? pos_y - st_reg.last_y : st_reg.last_y - pos_y;
        x_win = 16'h0001 << (x_code - 4'h1);
        y_win = 16'h0001 << (y_code - 4'h1);
        moved = ((x_code != 4'h0) && ({4'h0, dx} > x_win))
            || ((y_code != 4'h0) && ({4'h0, dy} > y_win));
        // direct mode or filter off logs everything
        keep_pos = direct_mode || !spatial_filter_enable
            || ((x_code == 4'h0) && (y_code == 4'h0))
            || !st_reg.have_last || moved;
    end

    // ==================================================
    // next state
    always_comb begin
        st_next = st_reg;
        st_next.pu_done = 1'b0;
        st_next.scan_start = 1'b0;
        st_next.aux_convert = 1'b0;
        st_next.pos_log = 1'b0;
        st_next.div = tick ? 8'h00 : st_reg.div + 8'h01;

        // register writes and read data
        if (reg_wr) begin
            case (reg_addr)
                PULLUP_TIMING_OFS: st_next.pullup_timing_cfg = reg_wdata;
                AUTO_TIMING_OFS: st_next.autonomous_timing_cfg = reg_wdata;
                APERTURE_OFS: st_next.aperture_cfg = reg_wdata;
                AUX_CFG_OFS: st_next.auxiliary_measure_cfg = reg_wdata;
                default: ;
            endcase
        end
        case (reg_addr)
            PULLUP_TIMING_OFS: st_next.rdata = st_reg.pullup_timing_cfg;
            AUTO_TIMING_OFS: st_next.rdata = st_reg.autonomous_timing_cfg;
            APERTURE_OFS: st_next.rdata = st_reg.aperture_cfg;
            AUX_CFG_OFS: st_next.rdata = st_reg.auxiliary_measure_cfg;
            default: st_next.rdata = 8'h00;
        endcase

        // pullup intervals after each measurement end, none for direct continuous commands
        case (st_reg.pu)
            PU_IDLE: begin
                if (meas_end && !(direct_mode && continuous_conversion_bit)) begin
                    if (coarse_code[3]) begin
                        st_next.pu = PU_COARSE;
                        st_next.pu_cnt = tst_ticks(COARSE_US[coarse_code[1:0]]);
                    end else begin
                        // minimum coarse: switch stays off, time added to fine
                        st_next.pu = PU_FINE;
                        st_next.pu_cnt = tst_ticks(FINE_US[fine_code]) + COARSE_MIN_TICKS;
                    end
                end
            end
            PU_COARSE: begin
                if (tick) begin
                    if (st_reg.pu_cnt <= TW'(1)) begin
                        st_next.pu = PU_FINE;
                        st_next.pu_cnt = tst_ticks(FINE_US[fine_code]);
                    end else begin
                        st_next.pu_cnt = st_reg.pu_cnt - TW'(1);
                    end
                end
            end
            PU_FINE: begin
                if (tick) begin
                    if (st_reg.pu_cnt <= TW'(1)) begin
                        st_next.pu = PU_IDLE;
                        st_next.pu_done = 1'b1;
                    end else begin
                        st_next.pu_cnt = st_reg.pu_cnt - TW'(1);
                    end
                end
            end
            default: st_next.pu = PU_IDLE;
        endcase

        // autonomous scan timing
        if (direct_mode) begin
            st_next.sc = SC_IDLE;
        end else begin
            case (st_reg.sc)
                SC_IDLE: begin
                    if (touch_start) begin
                        st_next.sc = SC_RUN;
                        st_next.sc_cnt = tst_ticks(TIME16_US[
                            st_reg.autonomous_timing_cfg[7:HI_NIB_LSB]]);
                    end
                end
                SC_RUN: begin
                    if (!touch_present) begin
                        st_next.sc = SC_IDLE;
                    end else if (tick) begin
                        if (st_reg.sc_cnt <= TW'(1)) begin
                            st_next.scan_start = 1'b1;
                            st_next.sc_cnt = tst_ticks(TIME16_US[
                                st_reg.autonomous_timing_cfg[HI_NIB_LSB-1:0]]);
                        end else begin
                            st_next.sc_cnt = st_reg.sc_cnt - TW'(1);
                        end
                    end
                end
                default: st_next.sc = SC_IDLE;
            endcase
        end

        // auxiliary delay then sampling
        case (st_reg.ax)
            AX_IDLE: begin
                if (aux_req && direct_mode) begin
                    st_next.ax = AX_DELAY;
                    st_next.ax_cnt = tst_ticks(AUX_DELAY_US[
                        st_reg.auxiliary_measure_cfg[7:AUX_DELAY_LSB]]);
                end
            end
            AX_DELAY: begin
                if (tick) begin
                    if (st_reg.ax_cnt <= TW'(1)) begin
                        st_next.ax = AX_SAMPLE;
                        st_next.ax_cnt = TW'(AUX_SAMPLE_BASE) << {
                            st_reg.auxiliary_measure_cfg[AUX_SAMPLE_LSB+1:AUX_SAMPLE_LSB],
                            1'b0};
                    end else begin
                        st_next.ax_cnt = st_reg.ax_cnt - TW'(1);
                    end
                end
            end
            AX_SAMPLE: begin
                if (tick) begin
                    if (st_reg.ax_cnt <= TW'(1)) begin
                        st_next.ax = AX_IDLE;
                        st_next.aux_convert = 1'b1;
                    end else begin
                        st_next.ax_cnt = st_reg.ax_cnt - TW'(1);
                    end
                end
            end
            default: st_next.ax = AX_IDLE;
        endcase

        // position logging through the aperture
        if (pos_valid && keep_pos) begin
            st_next.pos_log = 1'b1;
            st_next.last_x = pos_x;
            st_next.last_y = pos_y;
            st_next.have_last = 1'b1;
        end
        if (touch_start) begin
            st_next.have_last = 1'b0;
        end
    end

    // ==================================================
    // state register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '{pullup_timing_cfg: CFG_RESET, autonomous_timing_cfg: CFG_RESET,
                aperture_cfg: CFG_RESET, auxiliary_measure_cfg: CFG_RESET,
                pu: PU_IDLE, sc: SC_IDLE, ax: AX_IDLE, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    // ==================================================
    // outputs
    assign reg_rdata = st_reg.rdata;
    assign panel_pullup_switch = (st_reg.pu == PU_COARSE);
    assign pullup_busy = (st_reg.pu != PU_IDLE);
    assign pullup_done = st_reg.pu_done;
    assign scan_start = st_reg.scan_start;
    assign pos_log = st_reg.pos_log;
    assign aux_sampling = (st_reg.ax == AX_SAMPLE);
    assign aux_convert = st_reg.aux_convert;
    assign aux_averaging_depth = st_reg.auxiliary_measure_cfg[AUX_AVG_LSB+1:AUX_AVG_LSB];
    assign aux_median_filter = !median_or_straight_select;
    assign aux_resolution_select = st_reg.auxiliary_measure_cfg[AUX_RES_BIT];

    // ==================================================
    // checks
    AST_PU_START: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_reg.pu == PU_IDLE) && meas_end && !direct_mode |=> pullup_busy)
        else $error("pullup interval not entered after measurement");
    AST_CONTINUOUS_CONVERSION_BIT_SKIP: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_reg.pu == PU_IDLE) && meas_end && direct_mode && continuous_conversion_bit
        |=> !pullup_busy)
        else $error("continuous command entered pullup interval");
    AST_SW_LONG: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_reg.pu == PU_IDLE) && meas_end && !direct_mode && coarse_code[3]
        |=> panel_pullup_switch)
        else $error("pullup switch not engaged for long coarse");
    AST_SW_MIN: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_reg.pu == PU_IDLE) && meas_end && !direct_mode && !coarse_code[3]
        |=> !panel_pullup_switch until pullup_done)
        else $error("pullup switch engaged at minimum coarse");
    AST_SCAN_DIRECT: assert property (@(posedge ref_clk) disable iff (!rst_n)
        direct_mode |=> !scan_start)
        else $error("scan started in direct mode");
    AST_INIT_MIN: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_reg.sc == SC_IDLE) && touch_start && !direct_mode |=> !scan_start [*8])
        else $error("first scan before initial delay");
    AST_SPATIAL_FILTER_ENABLE_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n)
        pos_valid && !spatial_filter_enable |=> pos_log)
        else $error("position dropped with filter disabled");
    AST_SPATIAL_FILTER_ENABLE_DIRECT: assert property (@(posedge ref_clk) disable iff (!rst_n)
        pos_valid && direct_mode |=> pos_log)
        else $error("position dropped in direct mode");
    AST_AUX_DONE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $fell(aux_sampling) |-> aux_convert)
        else $error("sampling ended without conversion start");
    AST_REG_RW: assert property (@(posedge ref_clk) disable iff (!rst_n)
        reg_wr && (reg_addr == AUX_CFG_OFS) ##1 (reg_addr == AUX_CFG_OFS) && !reg_wr
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("register readback mismatch");
endmodule : tst_timing_cfg
`default_nettype wire

// ==== tb/tst_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// host processor side of the register port
module tst_host_model (
    // clock
    input wire logic ref_clk,
    // register port
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    input wire logic [7:0] reg_rdata,
    // mode and auxiliary request
    input wire logic direct_mode,
    output logic aux_req
);
    // idle values from time zero
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        aux_req = 1'b0;
    end

    // one write, strobe held over a single edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge ref_clk);
        #1;
        reg_wr = 1'b0;
        reg_wdata = ~d; // stale data no longer shown
    endtask : wr

    // read, data registered one edge after the address
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        #1;
        reg_addr = a;
        @(posedge ref_clk);
        #1;
        d = reg_rdata;
    endtask : rd

    // auxiliary request, never issued while scanning autonomously
    task automatic aux();
        @(posedge ref_clk);
        #1;
        if (direct_mode === 1'b1) aux_req = 1'b1;
        @(posedge ref_clk);
        #1;
        aux_req = 1'b0;
    endtask : aux
endmodule : tst_host_model
`default_nettype wire

// ==== tb/touch_scan_timing_config_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// testbench
module touch_scan_timing_config_tb;
    localparam int DV = 2;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
    logic reg_wr, aux_req;
    logic direct_mode = 1'b0;
    logic continuous_conversion_bit = 1'b0;
    logic meas_end = 1'b0;
    logic touch_start = 1'b0;
    logic touch_present = 1'b0;
    logic spatial_filter_enable = 1'b0;
    logic median_or_straight_select = 1'b0;
    logic pos_valid = 1'b0;
    logic [11:0] pos_x = 12'h000;
    logic [11:0] pos_y = 12'h000;
    logic panel_pullup_switch, pullup_busy, pullup_done, scan_start, pos_log;
    logic aux_sampling, aux_convert, aux_median_filter, aux_resolution_select;
    logic [1:0] aux_averaging_depth;
    int error_cnt = 0;
    int compares = 0;
    int n, nsw;
    // expected ticks of the 2MHz oscillator per case
    logic [7:0] pu_cfg [4] = '{8'h00, 8'h07, 8'h80, 8'h90};
    int pu_tk [4] = '{24, 1604, 2020, 4020};
    int sw_tk [4] = '{0, 0, 2000, 4000};
    logic [11:0] ap_x [7] = '{12'd100, 12'd101, 12'd105, 12'd105, 12'd105, 12'd106, 12'd107};
    logic [11:0] ap_y [7] = '{12'd100, 12'd101, 12'd100, 12'd101, 12'd96, 12'd96, 12'd96};
    logic [6:0] ap_log = 7'b1110101;
    logic [7:0] ax_cfg [2] = '{8'h07, 8'h2c};
    int ax_dly [2] = '{20, 200};
    int ax_smp [2] = '{4, 16};

    // clock
    always #5 ref_clk = ~ref_clk;

    tst_timing_cfg #(.DIV(DV)) tst_timing_cfg_i (
        .ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rdata,
        .direct_mode, .continuous_conversion_bit, .meas_end, .touch_start,
        .touch_present, .spatial_filter_enable, .median_or_straight_select,
        .pos_valid, .pos_x, .pos_y, .aux_req, .panel_pullup_switch, .pullup_busy,
        .pullup_done, .scan_start, .pos_log, .aux_sampling, .aux_convert,
        .aux_averaging_depth, .aux_median_filter, .aux_resolution_select
    );
    tst_host_model tst_host_model_i (
        .ref_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rdata, .direct_mode, .aux_req
    );

    // ==================================================
    // compare and drive helpers
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk_rng(input int got, input int lo, input int hi);
        compares++;
        if (got < lo || got > hi) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask : chk_rng

    // ticks to cycles, one tick plus 3 cycles of alignment slack
    task automatic near(input int got, input int tk);
        chk_rng(got, tk * DV - DV - 3, tk * DV + DV + 3);
    endtask : near

    function automatic logic sel(input int k);
        case (k)
            0: sel = pullup_done;
            1: sel = scan_start;
            2: sel = aux_convert;
            3: sel = pos_log;
            default: sel = aux_sampling;
        endcase
    endfunction : sel

    // cycles until the chosen output is high, -1 if never
    task automatic wait_hi(input int k, input int lim, output int cnt);
        cnt = 0;
        nsw = 0;
        while (sel(k) !== 1'b1 && cnt <= lim) begin
            @(posedge ref_clk);
            #1;
            cnt++;
            if (panel_pullup_switch === 1'b1) nsw++;
        end
        if (cnt > lim) cnt = -1;
    endtask : wait_hi

    // one-cycle pulse: 0 end of measurement, 1 touch, 2 position
    task automatic pulse(input int k);
        @(posedge ref_clk);
        #1;
        meas_end = (k == 0);
        touch_start = (k == 1);
        pos_valid = (k == 2);
        @(posedge ref_clk);
        #1;
        meas_end = 1'b0;
        touch_start = 1'b0;
        pos_valid = 1'b0;
    endtask : pulse

    task automatic give_verdict();
        $display("errors=%0d compares=%0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict

    // ==================================================
    // main sequence
    initial begin
        repeat (2) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        for (int a = 7; a <= 11; a++) begin
            tst_host_model_i.rd(8'(a), rv);
            chk8(rv, 8'h00);
            tst_host_model_i.wr(8'(a), 8'(a * 17 + 1));
            tst_host_model_i.rd(8'(a), rv);
            chk8(rv, (a == 11) ? 8'h00 : 8'(a * 17 + 1));
        end
        // busy must rise right after the end of measurement and drop with done
        for (int i = 0; i < 4; i++) begin
            tst_host_model_i.wr(8'h07, pu_cfg[i]);
            pulse(0);
            chk8({7'h00, pullup_busy}, 8'h01);
            wait_hi(0, 9000, n);
            near(n, pu_tk[i]);
            chk8({7'h00, pullup_busy}, 8'h00);
            if (sw_tk[i] == 0) chk_rng(nsw, 0, 0);
            else near(nsw, sw_tk[i]);
        end
        tst_host_model_i.wr(8'h07, 8'h00);
        direct_mode = 1'b1;
        pulse(0);
        chk8({7'h00, pullup_busy}, 8'h01);
        wait_hi(0, 200, n);
        near(n, 24);
        continuous_conversion_bit = 1'b1;
        pulse(0);
        chk8({7'h00, pullup_busy}, 8'h00);
        wait_hi(0, 200, n);
        chk_rng(n, -1, -1);
        continuous_conversion_bit = 1'b0;
        tst_host_model_i.wr(8'h08, 8'h01);
        touch_present = 1'b1;
        pulse(1);
        wait_hi(1, 300, n);
        chk_rng(n, -1, -1);
        direct_mode = 1'b0;
        pulse(1);
        wait_hi(1, 300, n);
        near(n, 20);
        @(posedge ref_clk);
        #1;
        wait_hi(1, 300, n);
        near(n + 1, 40);
        tst_host_model_i.wr(8'h09, 8'h22);
        for (int i = 0; i < 8; i++) begin
            spatial_filter_enable = (i != 5);
            direct_mode = (i == 6);
            pos_x = ap_x[i % 7];
            pos_y = ap_y[i % 7];
            if (i == 7) tst_host_model_i.wr(8'h09, 8'h00);
            pulse(2);
            wait_hi(3, 3, n);
            if (i == 7 || ap_log[i % 7]) chk_rng(n, 0, 3);
            else chk_rng(n, -1, -1);
        end
        touch_present = 1'b0;
        direct_mode = 1'b1;
        for (int i = 0; i < 2; i++) begin
            median_or_straight_select = i[0];
            tst_host_model_i.wr(8'h0a, ax_cfg[i]);
            tst_host_model_i.aux();
            wait_hi(4, 1000, n);
            near(n, ax_dly[i]);
            wait_hi(2, 1000, n);
            near(n, ax_smp[i]);
            chk8({6'h00, aux_averaging_depth}, {6'h00, ax_cfg[i][2:1]});
            chk8({7'h00, aux_resolution_select}, {7'h00, ax_cfg[i][0]});
            chk8({7'h00, aux_median_filter}, {7'h00, ~i[0]});
        end
        give_verdict();
    end

    // watchdog, about two and a half times the expected run
    initial begin
        #400000;
        error_cnt++;
        give_verdict();
    end
endmodule : touch_scan_timing_config_tb
`default_nettype wire
